// ### src/oag_addr_gen.sv
// operand effective-address generator with slice pointer registers
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module oag_addr_gen (
  // clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               resetn_i,
  // register port
  input  wire logic [7:0]         reg_addr_i,
  input  wire logic [7:0]         reg_wdata_i,
  input  wire logic               reg_we_i,
  input  wire logic               reg_re_i,
  output logic      [7:0]         reg_rdata_o,
  // decode request
  input  wire logic               req_valid_i,
  input  wire oag_pkg::oag_req_t  req_i,
  // decode result
  output logic                    res_valid_o,
  output oag_pkg::oag_res_t       res_o
);

  logic [7:0]         ptr_a_ff;
  logic [7:0]         ptr_b_ff;
  logic [1:0]         status_ff;
  logic [7:0]         rdata_ff;
  logic               res_valid_ff;
  oag_pkg::oag_res_t  res_ff;
  oag_pkg::oag_res_t  nxt_res;
  logic [7:0]         wreg_addr;
  logic [7:0]         op_addr;
  logic [15:0]        sext_disp;
  logic [15:0]        rel_sum;
  logic [7:0]         idx_rf_sum;
  logic [15:0]        idx_mem_sum;
  logic               is_rel_op;
  logic               legal;
  logic               wr_hit;

  // the byte-address form and the 4-bit form share one resolver
  assign wr_hit = (req_i.mode == oag_pkg::MD_WREG) ||
                  (req_i.reg_addr[7:4] == oag_pkg::WREG_NIBBLE);

  oag_wreg_resolve u_wreg (
    .nib_i   (req_i.reg_addr[3:0]),
    .ptr_a_i (ptr_a_ff),
    .ptr_b_i (ptr_b_ff),
    .addr_o  (wreg_addr)
  );

  // pairs always start on the even, high-byte address
  assign op_addr = wr_hit ? {wreg_addr[7:1], wreg_addr[0] & ~req_i.pair}
                          : {req_i.reg_addr[7:1],
                             req_i.reg_addr[0] & ~req_i.pair};

  assign sext_disp   = {{8{req_i.disp[7]}}, req_i.disp};
  assign rel_sum     = req_i.pc + sext_disp;
  assign idx_rf_sum  = req_i.disp + req_i.reg_val;
  assign idx_mem_sum = req_i.pair_val +
                       (req_i.wide ? req_i.word : sext_disp);

  always_comb begin
    unique case (req_i.op)
      oag_pkg::OP_SRJ, oag_pkg::OP_BTJF, oag_pkg::OP_BTJT,
      oag_pkg::OP_DECREMENT_JUMP_NONZERO, oag_pkg::OP_CIJE, oag_pkg::OP_CIJU: begin
        is_rel_op = 1'b1;
      end
      default: begin
        is_rel_op = 1'b0;
      end
    endcase
  end

  // which instructions accept which mode
  always_comb begin
    unique case (req_i.mode)
      oag_pkg::MD_IDX: begin
        unique case (req_i.space)
          oag_pkg::SP_RF:   legal = req_i.op == oag_pkg::OP_LD;
          oag_pkg::SP_PROG: legal = req_i.op == oag_pkg::OP_PMLOAD;
          oag_pkg::SP_EXT:  legal = req_i.op == oag_pkg::OP_EXLOAD;
          default:          legal = 1'b0;
        endcase
      end
      oag_pkg::MD_DIR: begin
        legal = (req_i.op == oag_pkg::OP_JUMP) ||
                (req_i.op == oag_pkg::OP_CALL) ||
                (req_i.op == oag_pkg::OP_PMLOAD) ||
                (req_i.op == oag_pkg::OP_EXLOAD);
      end
      oag_pkg::MD_IVEC: legal = req_i.op == oag_pkg::OP_CALL;
      oag_pkg::MD_REL:  legal = is_rel_op;
      oag_pkg::MD_IND:  legal = req_i.space != 2'h3;
      default:          legal = 1'b1;
    endcase
  end

  // effective address formation per mode
  always_comb begin
    nxt_res         = '0;
    nxt_res.illegal = ~legal;
    unique case (req_i.mode)
      oag_pkg::MD_REG, oag_pkg::MD_WREG: begin
        nxt_res.eaddr    = {8'h00, op_addr};
        nxt_res.operand  = req_i.pair ? req_i.pair_val
                                      : {8'h00, req_i.reg_val};
        nxt_res.is_value = 1'b1;
        nxt_res.space    = oag_pkg::SP_RF;
      end
      oag_pkg::MD_IND: begin
        nxt_res.space = req_i.space;
        if (req_i.space == oag_pkg::SP_RF) begin
          nxt_res.eaddr = {8'h00, req_i.reg_val};
          nxt_res.set2  = req_i.reg_val >= oag_pkg::SYS_BLK_BASE;
        end else begin
          nxt_res.eaddr = req_i.pair_val;
        end
      end
      oag_pkg::MD_IDX: begin
        nxt_res.space = req_i.space;
        if (req_i.space == oag_pkg::SP_RF) begin
          nxt_res.eaddr = {8'h00, idx_rf_sum};
          nxt_res.set2  = idx_rf_sum >= oag_pkg::SYS_BLK_BASE;
        end else begin
          nxt_res.eaddr = idx_mem_sum;
        end
      end
      oag_pkg::MD_DIR: begin
        nxt_res.eaddr   = req_i.word;
        nxt_res.pc_load = (req_i.op == oag_pkg::OP_JUMP) ||
                          (req_i.op == oag_pkg::OP_CALL);
        nxt_res.space   = (req_i.op == oag_pkg::OP_EXLOAD) ?
                          oag_pkg::SP_EXT : oag_pkg::SP_PROG;
      end
      oag_pkg::MD_IVEC: begin
        nxt_res.eaddr     = {8'h00, req_i.reg_addr};
        nxt_res.space     = oag_pkg::SP_PROG;
        nxt_res.vec_fetch = 1'b1;
      end
      oag_pkg::MD_REL: begin
        nxt_res.eaddr   = rel_sum;
        nxt_res.space   = oag_pkg::SP_PROG;
        nxt_res.pc_load = 1'b1;
      end
      oag_pkg::MD_IMM: begin
        nxt_res.operand  = req_i.wide ? req_i.word
                                      : {8'h00, req_i.disp};
        nxt_res.is_value = 1'b1;
      end
    endcase
  end

  // result register: one cycle after the request
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      res_valid_ff <= 1'b0;
      res_ff       <= '0;
    end else begin
      res_valid_ff <= req_valid_i;
      if (req_valid_i) begin
        res_ff <= nxt_res;
      end
    end
  end

  // slice pointers; software moves the working window here
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ptr_a_ff <= oag_pkg::PTR_A_RST;
      ptr_b_ff <= oag_pkg::PTR_B_RST;
    end else if (reg_we_i) begin
      if (reg_addr_i == oag_pkg::PTR_A_OFF) begin
        ptr_a_ff <= reg_wdata_i;
      end
      if (reg_addr_i == oag_pkg::PTR_B_OFF) begin
        ptr_b_ff <= reg_wdata_i;
      end
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status_ff <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (req_valid_i && ((i == oag_pkg::ST_ILLEGAL) ? nxt_res.illegal
                                                       : nxt_res.set2)) begin
          status_ff[i] <= 1'b1;
        end else if (reg_we_i && reg_addr_i == oag_pkg::STATUS_OFF &&
                     reg_wdata_i[i]) begin
          status_ff[i] <= 1'b0;
        end
      end
    end
  end

  // read data stand one cycle after the strobe only; unmapped reads zero
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_ff <= 8'h00;
    end else if (reg_re_i) begin
      unique case (reg_addr_i)
        oag_pkg::PTR_A_OFF:  rdata_ff <= ptr_a_ff;
        oag_pkg::PTR_B_OFF:  rdata_ff <= ptr_b_ff;
        oag_pkg::STATUS_OFF: rdata_ff <= {6'h00, status_ff};
        default:             rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign res_valid_o = res_valid_ff;
  assign res_o       = res_ff;

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  a_res_one_cycle: assert property (
    req_valid_i |=> res_valid_o ##1 (res_valid_o == $past(req_valid_i)))
    else $error("result not one cycle after request");

  a_wreg_slice_join: assert property (
    req_valid_i && req_i.mode == oag_pkg::MD_WREG && !req_i.pair |=>
    res_o.eaddr[7:0] == {($past(req_i.reg_addr[3]) ? $past(ptr_b_ff[7:3])
                          : $past(ptr_a_ff[7:3])),
                         $past(req_i.reg_addr[2:0])})
    else $error("working register address not pointer slice plus byte");

  a_byte_form_wreg: assert property (
    req_valid_i && req_i.mode == oag_pkg::MD_REG && !req_i.pair &&
    req_i.reg_addr[7:4] == oag_pkg::WREG_NIBBLE |=>
    res_o.eaddr == {8'h00, $past(req_i.reg_addr[3] ? ptr_b_ff[7:3]
                                                   : ptr_a_ff[7:3]),
                    $past(req_i.reg_addr[2:0])})
    else $error("1100B register address not resolved through pointer");

  a_pair_even: assert property (
    req_valid_i && req_i.pair && req_i.mode == oag_pkg::MD_REG |=>
    !res_o.eaddr[0])
    else $error("register pair at odd address");

  a_ind_sys_block: assert property (
    req_valid_i && req_i.mode == oag_pkg::MD_IND &&
    req_i.space == oag_pkg::SP_RF |=>
    res_o.set2 == (res_o.eaddr[7:6] == 2'b11))
    else $error("indirect access reached set 1 upper block");

  a_idx_sys_block: assert property (
    req_valid_i && req_i.mode == oag_pkg::MD_IDX &&
    req_i.space == oag_pkg::SP_RF |=>
    res_o.set2 == (res_o.eaddr[7:6] == 2'b11) && res_o.eaddr[15:8] == 8'h00)
    else $error("indexed access reached set 1 upper block");

  a_short_idx_sext: assert property (
    req_valid_i && req_i.mode == oag_pkg::MD_IDX && !req_i.wide &&
    req_i.space == oag_pkg::SP_EXT |=>
    res_o.eaddr == 16'($past(req_i.pair_val) +
                       {{8{$past(req_i.disp[7])}}, $past(req_i.disp)}))
    else $error("short indexed offset not sign extended");

  a_rel_target: assert property (
    req_valid_i && req_i.mode == oag_pkg::MD_REL |=>
    res_o.pc_load &&
    res_o.eaddr == 16'($past(req_i.pc) +
                       {{8{$past(req_i.disp[7])}}, $past(req_i.disp)}) &&
    res_o.illegal == !$past(is_rel_op))
    else $error("relative target wrong");

  a_vec_page_zero: assert property (
    req_valid_i && req_i.mode == oag_pkg::MD_IVEC |=>
    res_o.eaddr[15:8] == 8'h00 && res_o.vec_fetch &&
    res_o.illegal == ($past(req_i.op) != oag_pkg::OP_CALL))
    else $error("vector pointer outside first 256 bytes or not call");

  a_direct_pc: assert property (
    req_valid_i && req_i.mode == oag_pkg::MD_DIR &&
    req_i.op == oag_pkg::OP_JUMP |=> res_o.pc_load &&
    res_o.eaddr == $past(req_i.word) && !res_o.illegal)
    else $error("direct jump target not loaded");

  a_ptr_readback: assert property (
    reg_re_i && reg_addr_i == oag_pkg::PTR_A_OFF |=>
    reg_rdata_o == $past(ptr_a_ff))
    else $error("pointer read back wrong");

  a_ptr_b_write: assert property (
    reg_we_i && reg_addr_i == oag_pkg::PTR_B_OFF |=>
    ptr_b_ff == $past(reg_wdata_i))
    else $error("pointer write lost");

  a_imm_operand: assert property (
    req_valid_i && req_i.mode == oag_pkg::MD_IMM |=>
    res_o.is_value &&
    res_o.operand == ($past(req_i.wide) ? $past(req_i.word)
                                        : {8'h00, $past(req_i.disp)}))
    else $error("immediate operand not taken from the instruction");

  a_idx_rf_sum: assert property (
    req_valid_i && req_i.mode == oag_pkg::MD_IDX &&
    req_i.space == oag_pkg::SP_RF |=>
    res_o.eaddr[7:0] == 8'($past(req_i.disp) + $past(req_i.reg_val)) &&
    res_o.illegal == ($past(req_i.op) != oag_pkg::OP_LD))
    else $error("indexed register address or load-only check wrong");

  // a clear in the same cycle must not hide a new event
  a_status_sticky: assert property (
    req_valid_i && nxt_res.illegal |=> status_ff[oag_pkg::ST_ILLEGAL])
    else $error("illegal request not recorded in status");

  c_rel_jump: cover property (
    req_valid_i && req_i.mode == oag_pkg::MD_REL && is_rel_op);
  c_set2_redirect: cover property (req_valid_i && nxt_res.set2);
  c_ptr_write_use: cover property (
    reg_we_i && reg_addr_i == oag_pkg::PTR_B_OFF ##1
    req_valid_i && req_i.mode == oag_pkg::MD_WREG);

  c_idx_wide: cover property (
    req_valid_i && req_i.mode == oag_pkg::MD_IDX && req_i.wide);
  c_vec_call: cover property (
    req_valid_i && req_i.mode == oag_pkg::MD_IVEC &&
    req_i.op == oag_pkg::OP_CALL);

endmodule // oag_addr_gen

// ### src/oag_pkg.sv
// shared types and constants for the operand address generator
package oag_pkg;

  // register map on the plain register port
  localparam logic [7:0] PTR_A_OFF   = 8'hD6;
  localparam logic [7:0] PTR_B_OFF   = 8'hD7;
  localparam logic [7:0] STATUS_OFF  = 8'h00;

  // pointer values after reset: the common working area
  localparam logic [7:0] PTR_A_RST   = 8'hC0;
  localparam logic [7:0] PTR_B_RST   = 8'hC8;

  // upper system register block of set 1 and the working-form marker
  localparam logic [7:0] SYS_BLK_BASE = 8'hC0;
  localparam logic [3:0] WREG_NIBBLE  = 4'hC;

  // status register bit positions
  localparam int ST_ILLEGAL = 0;
  localparam int ST_SET2    = 1;

  // result latency in clock cycles
  localparam int RES_LATENCY = 1;

  typedef enum logic [3:0] {
    OP_OTHER  = 4'h0,
    OP_LD     = 4'h1,
    OP_PMLOAD = 4'h2,   // program_memory_load
    OP_EXLOAD = 4'h3,   // external_data_load
    OP_JUMP   = 4'h4,   // absolute_jump
    OP_CALL   = 4'h5,
    OP_SRJ    = 4'h6,   // short_relative_jump
    OP_BTJF   = 4'h7,   // bit_test_jump_false
    OP_BTJT   = 4'h8,   // bit_test_jump_true
    OP_DECREMENT_JUMP_NONZERO   = 4'h9,   // decrement_jump_nonzero
    OP_CIJE   = 4'hA,   // compare_inc_jump_equal
    OP_CIJU   = 4'hB    // compare_inc_jump_unequal
  } oag_op_t;

  typedef enum logic [2:0] {
    MD_REG  = 3'h0,     // register
    MD_WREG = 3'h1,     // 4-bit working register
    MD_IND  = 3'h2,     // indirect_register_mode
    MD_IDX  = 3'h3,     // indexed
    MD_DIR  = 3'h4,     // direct_mode
    MD_IVEC = 3'h5,     // indirect_vector_mode
    MD_REL  = 3'h6,     // pc_relative_mode
    MD_IMM  = 3'h7      // immediate_mode
  } oag_mode_t;

  typedef enum logic [1:0] {
    SP_RF   = 2'h0,
    SP_PROG = 2'h1,
    SP_EXT  = 2'h2
  } oag_space_t;

  typedef struct packed {
    oag_op_t    op;
    oag_mode_t  mode;
    oag_space_t space;     // target of indirect and indexed forms
    logic       pair;      // operand is a 16-bit register pair
    logic       wide;      // immediate or offset is one word
    logic [7:0] reg_addr;  // register, working nibble or vector pointer
    logic [7:0] disp;      // byte offset, displacement or byte immediate
    logic [15:0] word;     // word offset, address or word immediate
    logic [7:0] reg_val;   // content of the named register
    logic [15:0] pair_val; // content of the named register pair
    logic [15:0] pc;       // address of the following instruction
  } oag_req_t;

  typedef struct packed {
    logic [15:0] eaddr;    // effective address
    logic [15:0] operand;  // operand value for register and immediate
    oag_space_t  space;
    logic        set2;     // upper block access goes to set 2
    logic        is_value; // operand field carries the value
    logic        pc_load;  // eaddr is the next fetch address
    logic        vec_fetch;// eaddr points at a vector pair
    logic        illegal;  // mode not allowed for this instruction
  } oag_res_t;

endpackage

// ### src/oag_wreg_resolve.sv
// working register address resolver: pointer slice plus byte in slice
`timescale 1ns/1ps
module oag_wreg_resolve (
  // working register nibble
  input  wire logic [3:0] nib_i,
  // slice pointers
  input  wire logic [7:0] ptr_a_i,
  input  wire logic [7:0] ptr_b_i,
  // resolved register file address
  output logic      [7:0] addr_o
);

  always_comb begin
    if (nib_i[3]) begin
      addr_o = {ptr_b_i[7:3], nib_i[2:0]};
    end else begin
      addr_o = {ptr_a_i[7:3], nib_i[2:0]};
    end
  end

endmodule // oag_wreg_resolve

// ### verification/oag_addr_gen_tb.sv
// self-checking bench for the operand address generator
`timescale 1ns/1ps
module oag_addr_gen_tb;
  logic              sys_clk_i;
  logic              resetn_i;
  logic [7:0]        reg_addr_i;
  logic [7:0]        reg_wdata_i;
  logic              reg_we_i;
  logic              reg_re_i;
  logic [7:0]        reg_rdata_o;
  logic              req_valid_i;
  oag_pkg::oag_req_t req_i;
  logic              res_valid_o;
  oag_pkg::oag_res_t res_o;
  oag_pkg::oag_req_t q;
  logic [7:0]        rd;
  int                n_fail;
  int                total_checks;
  int                cyc = 0;

  oag_mem_model rf ();

  oag_addr_gen oag_addr_gen_inst (
    .sys_clk_i   (sys_clk_i),
    .resetn_i    (resetn_i),
    .reg_addr_i  (reg_addr_i),
    .reg_wdata_i (reg_wdata_i),
    .reg_we_i    (reg_we_i),
    .reg_re_i    (reg_re_i),
    .reg_rdata_o (reg_rdata_o),
    .req_valid_i (req_valid_i),
    .req_i       (req_i),
    .res_valid_o (res_valid_o),
    .res_o       (res_o)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  task automatic end_sim;
    if (n_fail == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic ck(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic rreg(input logic [7:0] a);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_re_i <= 1'b0;
    #1 rd = reg_rdata_o;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_we_i <= 1'b0;
  endtask

  // w doubles as pc; register contents come from the model
  function automatic oag_pkg::oag_req_t mk(
    input oag_pkg::oag_op_t o, input oag_pkg::oag_mode_t m,
    input oag_pkg::oag_space_t s, input logic [1:0] f,
    input logic [7:0] ra, input logic [7:0] d, input logic [15:0] w);
    oag_pkg::oag_req_t r;
    r = '0;
    r.op = o;
    r.mode = m;
    r.space = s;
    r.pair = f[0];
    r.wide = f[1];
    r.reg_addr = ra;
    r.disp = d;
    r.word = w;
    r.pc = w;
    r.reg_val = rf.rd8(ra);
    r.pair_val = rf.rd16(ra);
    return r;
  endfunction

  task automatic go(input oag_pkg::oag_req_t r, input logic [15:0] ea,
                    input logic il);
    @(posedge sys_clk_i);
    req_i <= r;
    req_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    req_valid_i <= 1'b0;
    #1;
    ck("res_valid", 16'h1, 16'(res_valid_o));
    ck("eaddr", ea, res_o.eaddr);
    ck("illegal", 16'(il), 16'(res_o.illegal));
    @(posedge sys_clk_i);
    #1 ck("res_valid_drop", 16'h0, 16'(res_valid_o));
  endtask

  task automatic t_reset_wreg;
    rreg(oag_pkg::PTR_A_OFF);
    ck("ptr_a_rst", 16'h00C0, 16'(rd));
    rreg(oag_pkg::PTR_B_OFF);
    ck("ptr_b_rst", 16'h00C8, 16'(rd));
    q = mk(oag_pkg::OP_LD, oag_pkg::MD_REG, oag_pkg::SP_RF, 2'h0,
           8'hCB, 8'h0, 16'h0);
    go(q, 16'h00CB, 1'b0);
  endtask

  task automatic t_ptr_regs;
    rreg(8'h55);
    ck("unmapped", 16'h0, 16'(rd));
    wreg(oag_pkg::PTR_B_OFF, 8'hA8);
    wreg(oag_pkg::PTR_A_OFF, 8'h70);
    rreg(oag_pkg::PTR_B_OFF);
    ck("ptr_b", 16'h00A8, 16'(rd));
    rreg(oag_pkg::PTR_A_OFF);
    ck("ptr_a", 16'h0070, 16'(rd));
    q = mk(oag_pkg::OP_LD, oag_pkg::MD_REG, oag_pkg::SP_RF, 2'h0,
           8'hCB, 8'h0, 16'h0);
    go(q, 16'h00AB, 1'b0);
    q = mk(oag_pkg::OP_LD, oag_pkg::MD_WREG, oag_pkg::SP_RF, 2'h0,
           8'h06, 8'h0, 16'h0);
    go(q, 16'h0076, 1'b0);
    q = mk(oag_pkg::OP_LD, oag_pkg::MD_REG, oag_pkg::SP_RF, 2'h1,
           8'h41, 8'h0, 16'h0);
    go(q, 16'h0040, 1'b0);
    ck("pair_operand", 16'hBFBE, res_o.operand);
  endtask

  task automatic t_indirect;
    q = mk(oag_pkg::OP_LD, oag_pkg::MD_IND, oag_pkg::SP_RF, 2'h0,
           8'h2A, 8'h0, 16'h0);
    go(q, 16'h00D5, 1'b0);
    ck("ind_set2", 16'h1, 16'(res_o.set2));
    q = mk(oag_pkg::OP_LD, oag_pkg::MD_IND, oag_pkg::SP_RF, 2'h0,
           8'h40, 8'h0, 16'h0);
    go(q, 16'h00BF, 1'b0);
    ck("ind_low", 16'h0, 16'(res_o.set2));
    q = mk(oag_pkg::OP_EXLOAD, oag_pkg::MD_IND, oag_pkg::SP_EXT, 2'h1,
           8'h40, 8'h0, 16'h0);
    go(q, 16'hBFBE, 1'b0);
    ck("ind_space", 16'(oag_pkg::SP_EXT), 16'(res_o.space));
  endtask

  task automatic t_indexed;
    q = mk(oag_pkg::OP_LD, oag_pkg::MD_IDX, oag_pkg::SP_RF, 2'h0,
           8'h40, 8'h51, 16'h0);
    go(q, 16'h0010, 1'b0);
    q.disp = 8'h01;
    go(q, 16'h00C0, 1'b0);
    ck("idx_set2", 16'h1, 16'(res_o.set2));
    q.op = oag_pkg::OP_OTHER;
    go(q, 16'h00C0, 1'b1);
    q = mk(oag_pkg::OP_EXLOAD, oag_pkg::MD_IDX, oag_pkg::SP_EXT, 2'h1,
           8'h40, 8'h80, 16'h4050);
    go(q, 16'hBF3E, 1'b0);
    q.wide = 1'b1;
    go(q, 16'h000E, 1'b0);
    q.space = oag_pkg::SP_PROG;
    go(q, 16'h000E, 1'b1);
    q.op = oag_pkg::OP_PMLOAD;
    go(q, 16'h000E, 1'b0);
  endtask

  task automatic t_direct;
    q = mk(oag_pkg::OP_JUMP, oag_pkg::MD_DIR, oag_pkg::SP_PROG, 2'h0,
           8'h0, 8'h0, 16'h1234);
    go(q, 16'h1234, 1'b0);
    ck("jump_pc_load", 16'h1, 16'(res_o.pc_load));
    q.op = oag_pkg::OP_CALL;
    go(q, 16'h1234, 1'b0);
    ck("call_pc_load", 16'h1, 16'(res_o.pc_load));
    q.op = oag_pkg::OP_PMLOAD;
    go(q, 16'h1234, 1'b0);
    ck("load_pc_load", 16'h0, 16'(res_o.pc_load));
    q.op = oag_pkg::OP_LD;
    go(q, 16'h1234, 1'b1);
  endtask

  task automatic t_vector_imm;
    q = mk(oag_pkg::OP_CALL, oag_pkg::MD_IVEC, oag_pkg::SP_PROG, 2'h0,
           8'h34, 8'h0, 16'hFF00);
    go(q, 16'h0034, 1'b0);
    ck("vec_fetch", 16'h1, 16'(res_o.vec_fetch));
    q.op = oag_pkg::OP_JUMP;
    go(q, 16'h0034, 1'b1);
    q = mk(oag_pkg::OP_LD, oag_pkg::MD_IMM, oag_pkg::SP_RF, 2'h0,
           8'h0, 8'hAA, 16'hBEEF);
    go(q, 16'h0000, 1'b0);
    ck("imm_byte", 16'h00AA, res_o.operand);
    ck("imm_value", 16'h1, 16'(res_o.is_value));
    q.wide = 1'b1;
    go(q, 16'h0000, 1'b0);
    ck("imm_word", 16'hBEEF, res_o.operand);
  endtask

  task automatic t_relative;
    for (int k = 6; k < 12; k++) begin
      q = mk(oag_pkg::oag_op_t'(4'(k)), oag_pkg::MD_REL,
             oag_pkg::SP_PROG, 2'h0, 8'h0, 8'hFE, 16'h1000);
      go(q, 16'h0FFE, 1'b0);
      ck("rel_pc_load", 16'h1, 16'(res_o.pc_load));
    end
    q.pc = 16'hFFF0;
    q.disp = 8'h20;
    go(q, 16'h0010, 1'b0);
    q.op = oag_pkg::OP_LD;
    go(q, 16'h0010, 1'b1);
  endtask

  // requests on consecutive edges, each answered one cycle later
  task automatic t_back_to_back;
    q = mk(oag_pkg::OP_SRJ, oag_pkg::MD_REL, oag_pkg::SP_PROG, 2'h0,
           8'h0, 8'h10, 16'h2000);
    @(posedge sys_clk_i);
    req_i <= q;
    req_valid_i <= 1'b1;
    q.pc = 16'h3000;
    @(posedge sys_clk_i);
    req_i <= q;
    #1 ck("b2b_first", 16'h2010, res_o.eaddr);
    @(posedge sys_clk_i);
    req_valid_i <= 1'b0;
    #1 ck("b2b_second", 16'h3010, res_o.eaddr);
    ck("b2b_valid", 16'h1, 16'(res_valid_o));
  endtask

  // sticky illegal and set2 flags, cleared by writing ones
  task automatic t_status;
    rreg(oag_pkg::STATUS_OFF);
    ck("st_illegal", 16'h1, 16'(rd[oag_pkg::ST_ILLEGAL]));
    ck("st_set2", 16'h1, 16'(rd[oag_pkg::ST_SET2]));
    wreg(oag_pkg::STATUS_OFF, 8'h03);
    rreg(oag_pkg::STATUS_OFF);
    ck("st_cleared", 16'h0, 16'(rd));
  endtask

  // reset in mid-run brings the moved pointer A back to the common area
  task automatic t_mid_reset;
    @(posedge sys_clk_i);
    resetn_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    ck("valid_in_rst", 16'h0, 16'(res_valid_o));
    resetn_i <= 1'b1;
    rreg(oag_pkg::PTR_A_OFF);
    ck("ptr_a_rerst", 16'h00C0, 16'(rd));
  endtask

  initial begin
    n_fail = 0;
    total_checks = 0;
    resetn_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    req_valid_i = 1'b0;
    req_i = '0;
    repeat (3) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    t_reset_wreg();
    t_ptr_regs();
    t_indirect();
    t_indexed();
    t_direct();
    t_vector_imm();
    t_relative();
    t_back_to_back();
    t_status();
    t_mid_reset();
    end_sim();
  end
endmodule // oag_addr_gen_tb

// ### verification/oag_mem_model.sv
// register file model feeding register and pair contents to the decoder
`timescale 1ns/1ps
module oag_mem_model;
  logic [7:0] rf_mem [256];

  // descending pattern so every byte and pair is distinct
  initial begin
    for (int i = 0; i < 256; i++) begin
      rf_mem[i] = 8'hFF - 8'(i);
    end
  end

  // any byte register may serve as a pointer to another register
  function automatic logic [7:0] rd8(input logic [7:0] a);
    return rf_mem[a];
  endfunction

  // a pair reads high byte from the even address, low from the odd one
  function automatic logic [15:0] rd16(input logic [7:0] a);
    return {rf_mem[{a[7:1], 1'b0}], rf_mem[{a[7:1], 1'b1}]};
  endfunction
endmodule // oag_mem_model
